// file: frbs_pkg.sv
package frbs_pkg;

	// ==================================================
	// clock and timing figures
	// ==================================================
	localparam int CLK_MHZ = 40; // i_mclk rate
	localparam int POR_WAIT_US = 400; // por detect to copy start
	localparam int COPY_US = 70; // boot code copy duration
	localparam int RECOVER_US = 10; // reset release to ready
	localparam int SLOAD_US = 35; // sector load, max
	localparam int PLOAD_US = 45; // page load, max
	localparam int SPROG_US = 720; // sector program, max
	localparam int PPROG_US = 750; // page program, max
	localparam int ERASE1_MS = 3; // one block erase or resume
	localparam int ERASEN_MS = 6; // 2 to 64 block erase or resume
	localparam int SUSP_US = 500; // erase suspend, max
	localparam int OTP_NS = 700; // otp access and lock ops, max
	localparam int VERIFY_US = 100; // multi block erase verify, max

	// only the otp time divides and rounds down, none below one cycle
	localparam int POR_WAIT_CYC = POR_WAIT_US * CLK_MHZ;
	localparam int COPY_CYC = COPY_US * CLK_MHZ;
	localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
	localparam int SLOAD_CYC = SLOAD_US * CLK_MHZ;
	localparam int PLOAD_CYC = PLOAD_US * CLK_MHZ;
	localparam int SPROG_CYC = SPROG_US * CLK_MHZ;
	localparam int PPROG_CYC = PPROG_US * CLK_MHZ;
	localparam int ERASE1_CYC = ERASE1_MS * 1000 * CLK_MHZ;
	localparam int ERASEN_CYC = ERASEN_MS * 1000 * CLK_MHZ;
	localparam int SUSP_CYC = SUSP_US * CLK_MHZ;
	localparam int OTP_CYC = (OTP_NS * CLK_MHZ / 1000 < 1) ? 1 :
		OTP_NS * CLK_MHZ / 1000;
	localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ;

	// ==================================================
	// boot copy geometry
	// ==================================================
	localparam int COPY_BYTES = 1024; // sectors 0,1 of page 0 block 0
	localparam int COPY_WORDS = COPY_BYTES / 2; // 16-bit words
	localparam int COPY_STEP = COPY_CYC / COPY_WORDS; // cycles per word
	localparam int TMR_W = 24; // timer width

	// ==================================================
	// boot partition and command codes
	// ==================================================
	localparam logic [15:0] BP_LO_END = 16'h01ff;
	localparam logic [15:0] BP_HI_START = 16'h8000;
	localparam logic [15:0] BP_HI_END = 16'h800f;
	localparam logic [15:0] CMD_RST_BP = 16'h00f0; // boot partition reset
	localparam logic [15:0] CMD_RST_CORE = 16'h00f3; // reset tied to f220h
	localparam logic [15:0] CORE_RST_LOC = 16'hf220;
	localparam logic [11:0] CMD_OP_PREFIX = 12'h000; // ops are 000x

	// operation kinds, low nibble of an op command
	typedef enum logic [3:0] {
		OP_SLOAD = 4'h0,
		OP_PLOAD = 4'h1,
		OP_SPROG = 4'h2,
		OP_PPROG = 4'h3,
		OP_ERASE1 = 4'h4,
		OP_ERASEN = 4'h5,
		OP_SUSP = 4'h6,
		OP_RES1 = 4'h7,
		OP_RESN = 4'h8,
		OP_OTP = 4'h9,
		OP_LOCK = 4'ha,
		OP_VERIFY = 4'hb
	} frbs_op_type;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_PWR = 7'h01,
		ST_POR_WAIT = 7'h02,
		ST_COPY = 7'h04,
		ST_PIN_WAIT = 7'h08,
		ST_READY = 7'h10,
		ST_HOLD = 7'h20,
		ST_RECOVER = 7'h40
	} frbs_state_type;

endpackage

// file: frbs_tmr_if.sv
`timescale 1ns/10ps
// timer request and completion between sequencer and its timer
interface frbs_tmr_if;
	import frbs_pkg::*;
	logic start; // load a new count
	logic [TMR_W-1:0] load; // cycles to run
	logic done; // one-cycle pulse at expiry
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface

// file: frbs_timer.sv
`timescale 1ns/10ps
module frbs_timer
	import frbs_pkg::*;
(
	input wire logic i_mclk, // system clock
	input wire logic i_reset_n, // async reset, active low
	frbs_tmr_if.tmr tm // request and expiry
);

	// ==================================================
	// down counter
	// ==================================================
	logic [TMR_W-1:0] cnt; // cycles left
	logic done; // expiry pulse
	logic [TMR_W-1:0] next_cnt;
	logic next_done;

	// a new start overrides a running count
	always_comb begin
		next_cnt = cnt;
		next_done = 1'b0;
		if (tm.start) begin
			next_cnt = tm.load;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
			next_done = (cnt == {{(TMR_W-1){1'b0}}, 1'b1});
		end
	end

	// registers only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt <= '0;
			done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			done <= next_done;
		end
	end

	assign tm.done = done;

endmodule

// file: frbs_sequencer.sv
`timescale 1ns/10ps
module frbs_sequencer
	import frbs_pkg::*;
#(
	parameter int POR_WAIT = POR_WAIT_CYC, // power-on wait cycles
	parameter int SPROG = SPROG_CYC, // sector program cycles
	parameter int PPROG = PPROG_CYC, // page program cycles
	parameter int ERASE1 = ERASE1_CYC, // single erase cycles
	parameter int ERASEN = ERASEN_CYC, // multi erase cycles
	parameter int SUSP = SUSP_CYC, // suspend cycles
	parameter int WORDS = COPY_WORDS, // boot words copied
	parameter int STEP = COPY_STEP // cycles per copied word
) (
	input wire logic i_mclk, // system clock
	input wire logic i_reset_n, // async reset, active low
	input wire logic i_por_det, // power-on detect, async
	input wire logic i_reset_pin_n, // reset pin, async, low
	input wire logic i_cmd_valid, // command written, pulse
	input wire logic [15:0] i_cmd_code, // command code
	input wire logic i_int_clear, // host writes int bit 0
	input wire logic i_rd_valid, // buffer read request
	input wire logic [15:0] i_rd_addr, // buffer read address
	input wire logic i_rd_status, // status register read
	output logic o_int, // completion flag
	output logic o_busy, // operation in progress
	output logic o_ready, // ready state, commands decoded
	output logic o_suspended, // erase suspended
	output logic o_copy_we, // boot buffer word write
	output logic [9:0] o_copy_addr, // boot buffer word index
	output logic o_regs_init, // register init pulse
	output logic o_reset_scope, // 1: core reset (f220h)
	output logic o_rd_grant, // read accepted pulse
	output logic o_rd_deny, // read refused pulse
	output logic o_cmd_deny // command refused pulse
);

	// ==================================================
	// helpers
	// ==================================================
	function automatic logic in_boot_part(input logic [15:0] a);
		in_boot_part = (a <= BP_LO_END) ||
			(a >= BP_HI_START && a <= BP_HI_END);
	endfunction

	function automatic logic [TMR_W-1:0] cyc(input int n);
		cyc = TMR_W'(n);
	endfunction

	// op duration, worst case so the flag never comes late
	function automatic logic [TMR_W-1:0] op_cycles(input frbs_op_type k);
		case (k)
			OP_SLOAD: op_cycles = cyc(SLOAD_CYC);
			OP_PLOAD: op_cycles = cyc(PLOAD_CYC);
			OP_SPROG: op_cycles = cyc(SPROG);
			OP_PPROG: op_cycles = cyc(PPROG);
			OP_ERASE1, OP_RES1: op_cycles = cyc(ERASE1);
			OP_ERASEN, OP_RESN: op_cycles = cyc(ERASEN);
			OP_SUSP: op_cycles = cyc(SUSP);
			OP_OTP, OP_LOCK: op_cycles = cyc(OTP_CYC);
			OP_VERIFY: op_cycles = cyc(VERIFY_CYC);
			default: op_cycles = cyc(1);
		endcase
	endfunction

	// ==================================================
	// pin synchronisers
	// ==================================================
	logic por_m, por_s; // power-on detect stages
	logic pin_m, pin_s; // reset pin stages

	// first stages feed only the second stages
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			por_m <= 1'b0;
			por_s <= 1'b0;
			pin_m <= 1'b0;
			pin_s <= 1'b0;
		end else begin
			por_m <= i_por_det;
			por_s <= por_m;
			pin_m <= i_reset_pin_n;
			pin_s <= pin_m;
		end
	end

	// ==================================================
	// timer
	// ==================================================
	frbs_tmr_if tm ();

	frbs_timer u_timer (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.tm(tm.tmr)
	);

	// ==================================================
	// sequencer state
	// ==================================================
	frbs_state_type state, next_state;
	frbs_op_type kind, next_kind; // running operation
	logic int_flag, next_int_flag;
	logic busy, next_busy;
	logic susp, next_susp;
	logic [9:0] waddr, next_waddr; // copy word index
	logic [9:0] copy_idx, next_copy_idx; // index of the word just written
	logic [7:0] step, next_step; // cycles within a word
	logic copy_we, next_copy_we;
	logic regs_init, next_regs_init;
	logic scope, next_scope;
	logic rd_grant, next_rd_grant;
	logic rd_deny, next_rd_deny;
	logic cmd_deny, next_cmd_deny;
	logic is_rst_cmd; // reset command decode
	logic is_op_cmd; // operation command decode
	frbs_op_type cmd_kind;

	assign is_rst_cmd = i_cmd_valid &&
		(i_cmd_code == CMD_RST_BP || i_cmd_code == CMD_RST_CORE);
	assign is_op_cmd = i_cmd_valid && i_cmd_code[15:4] == CMD_OP_PREFIX &&
		i_cmd_code[3:0] <= OP_VERIFY;
	assign cmd_kind = frbs_op_type'(i_cmd_code[3:0]);

	// next-state and flag logic
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_int_flag = int_flag;
		next_busy = busy;
		next_susp = susp;
		next_waddr = waddr;
		next_copy_idx = copy_idx;
		next_step = step;
		next_copy_we = 1'b0;
		next_regs_init = 1'b0;
		next_scope = scope;
		next_rd_grant = 1'b0;
		next_rd_deny = 1'b0;
		next_cmd_deny = 1'b0;
		tm.start = 1'b0;
		tm.load = '0;
		// host clear; a completion below still wins
		if (i_int_clear) begin
			next_int_flag = 1'b0;
		end
		case (state)
			ST_PWR: begin
				if (por_s) begin
					tm.start = 1'b1;
					tm.load = cyc(POR_WAIT);
					next_state = ST_POR_WAIT;
				end
			end
			ST_POR_WAIT: begin
				if (tm.done) begin
					next_waddr = '0;
					next_step = '0;
					next_state = ST_COPY;
				end
			end
			ST_COPY: begin
				// paced word writes spread the copy over its time
				if (step == 8'(STEP - 1)) begin
					next_step = '0;
					next_copy_we = 1'b1;
					// index leaves with its strobe, before waddr moves on
					next_copy_idx = waddr;
					if (waddr == 10'(WORDS - 1)) begin
						next_state = ST_PIN_WAIT;
					end else begin
						next_waddr = waddr + 10'h001;
					end
				end else begin
					next_step = step + 8'h01;
				end
			end
			ST_PIN_WAIT: begin
				// flag waits for both copy done and pin high
				if (pin_s) begin
					next_int_flag = 1'b1;
					next_state = ST_READY;
				end
			end
			ST_READY: begin
				if (!pin_s) begin
					next_state = ST_HOLD;
					next_regs_init = 1'b1;
					next_busy = 1'b0;
					next_susp = 1'b0;
					next_int_flag = 1'b0;
					next_scope = 1'b0;
				end else if (is_rst_cmd) begin
					next_state = ST_RECOVER;
					next_scope = (i_cmd_code == CMD_RST_CORE);
					next_regs_init = 1'b1;
					next_busy = 1'b0;
					next_susp = 1'b0;
					next_int_flag = 1'b0;
					tm.start = 1'b1;
					tm.load = cyc(RECOVER_CYC);
				end else if (busy && tm.done) begin
					// still busy at this edge, so an op command here is refused
					next_cmd_deny = is_op_cmd;
					next_busy = 1'b0;
					next_int_flag = 1'b1;
					next_susp = (kind == OP_SUSP);
				end else if (is_op_cmd) begin
					// suspend only breaks a running OP_ERASE1 or OP_ERASEN erase
					if (busy && cmd_kind == OP_SUSP &&
						(kind == OP_ERASE1 || kind == OP_ERASEN)) begin
						next_kind = cmd_kind;
						next_int_flag = 1'b0;
						tm.start = 1'b1;
						tm.load = op_cycles(cmd_kind);
					end else if (busy || (cmd_kind == OP_SUSP) ||
						((cmd_kind == OP_RES1 || cmd_kind == OP_RESN) &&
						!susp)) begin
						next_cmd_deny = 1'b1;
					end else begin
						next_kind = cmd_kind;
						next_busy = 1'b1;
						next_susp = 1'b0;
						next_int_flag = 1'b0;
						tm.start = 1'b1;
						tm.load = op_cycles(cmd_kind);
					end
				end
			end
			ST_HOLD: begin
				// pin low: held in reset, buffers untouched
				if (pin_s) begin
					tm.start = 1'b1;
					tm.load = cyc(RECOVER_CYC);
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (!pin_s) begin
					next_state = ST_HOLD;
				end else if (tm.done) begin
					next_int_flag = 1'b1;
					next_state = ST_READY;
				end
			end
			default: begin
				next_state = ST_PWR;
			end
		endcase
		// commands outside ready are refused
		if (i_cmd_valid && state != ST_READY) begin
			next_cmd_deny = 1'b1;
		end else if (i_cmd_valid && !is_rst_cmd && !is_op_cmd) begin
			next_cmd_deny = 1'b1;
		end
		// read gating; status always answers
		if (i_rd_status) begin
			next_rd_grant = 1'b1;
		end else if (i_rd_valid) begin
			if (state == ST_READY) begin
				next_rd_grant = 1'b1;
			end else if ((state == ST_PIN_WAIT || state == ST_RECOVER) &&
				in_boot_part(i_rd_addr)) begin
				next_rd_grant = 1'b1;
			end else begin
				next_rd_deny = 1'b1;
			end
		end
	end

	// registers only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_PWR;
			kind <= OP_SLOAD;
			int_flag <= 1'b0;
			busy <= 1'b0;
			susp <= 1'b0;
			waddr <= '0;
			copy_idx <= '0;
			step <= '0;
			copy_we <= 1'b0;
			regs_init <= 1'b0;
			scope <= 1'b0;
			rd_grant <= 1'b0;
			rd_deny <= 1'b0;
			cmd_deny <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			int_flag <= next_int_flag;
			busy <= next_busy;
			susp <= next_susp;
			waddr <= next_waddr;
			copy_idx <= next_copy_idx;
			step <= next_step;
			copy_we <= next_copy_we;
			regs_init <= next_regs_init;
			scope <= next_scope;
			rd_grant <= next_rd_grant;
			rd_deny <= next_rd_deny;
			cmd_deny <= next_cmd_deny;
		end
	end

	// ==================================================
	// outputs, all from flip-flops
	// ==================================================
	logic ready_q; // registered ready view
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (next_state == ST_READY);
		end
	end

	assign o_int = int_flag;
	assign o_busy = busy;
	assign o_ready = ready_q;
	assign o_suspended = susp;
	assign o_copy_we = copy_we;
	assign o_copy_addr = copy_idx;
	assign o_regs_init = regs_init;
	assign o_reset_scope = scope;
	assign o_rd_grant = rd_grant;
	assign o_rd_deny = rd_deny;
	assign o_cmd_deny = cmd_deny;

endmodule

// file: frbs_sequencer_asserts.sv
`timescale 1ns/10ps
// port-level checks of the reset and boot sequencer
module frbs_sequencer_asserts
	import frbs_pkg::*;
#(
	parameter int WORDS = COPY_WORDS // boot words copied
) (
	input wire logic i_mclk, // clock
	input wire logic i_reset_n, // power reset
	input wire logic i_reset_pin_n, // reset pin
	input wire logic i_cmd_valid, // command strobe
	input wire logic [15:0] i_cmd_code, // command code
	input wire logic i_rd_valid, // buffer read
	input wire logic [15:0] i_rd_addr, // read address
	input wire logic i_rd_status, // status read
	input wire logic o_int, // completion flag
	input wire logic o_busy, // op running
	input wire logic o_ready, // ready
	input wire logic o_suspended, // erase suspended
	input wire logic o_copy_we, // copy write
	input wire logic [9:0] o_copy_addr, // copy index
	input wire logic o_regs_init, // init pulse
	input wire logic o_reset_scope, // core reset
	input wire logic o_rd_grant, // read granted
	input wire logic o_rd_deny, // read refused
	input wire logic o_cmd_deny // command refused
);
	// ====
	// copy word counter
	// ====
	logic [10:0] n_wr; // words written since reset
	logic [10:0] next_n_wr; // next count
	// a stuck or skipped index shows against this count
	always_comb begin
		next_n_wr = n_wr + {10'h000, o_copy_we};
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			n_wr <= 11'h000;
		end else begin
			n_wr <= next_n_wr;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// ====
	// sequences
	// ====
	sequence s_take; // command met in ready and idle
		i_cmd_valid && o_ready && !o_busy;
	endsequence
	sequence s_recover; // out of ready a while, then back
		!o_ready [*8] ##[1:420] o_ready;
	endsequence
	// ====
	// properties
	// ====
	a_copy_index: assert property (o_copy_we |-> o_copy_addr == n_wr[9:0])
		else $error("copy index out of order");
	a_copy_total: assert property ($rose(o_ready) |-> n_wr == WORDS)
		else $error("ready before whole boot copy");
	a_pin_holds: assert property (!i_reset_pin_n [*6] |-> !o_ready)
		else $error("ready while reset pin low");
	a_busy_flag: assert property (o_busy |-> !o_int)
		else $error("flag high while busy");
	a_op_start: assert property (s_take ##0 i_cmd_code[15:2] == 14'h0000
		|=> o_busy && !o_int) else $error("op not started");
	a_busy_refuse: assert property (i_cmd_valid && o_busy
		&& i_cmd_code[15:2] == 14'h0000 |=> o_cmd_deny)
		else $error("op taken while busy");
	a_unready_cmd: assert property (i_cmd_valid && !o_ready |=> o_cmd_deny)
		else $error("command taken outside ready");
	a_read_answer: assert property (i_rd_valid || i_rd_status
		|=> o_rd_grant != o_rd_deny) else $error("read answer not single");
	a_status_grant: assert property (i_rd_status |=> o_rd_grant)
		else $error("status read refused");
	a_outside_part: assert property (i_rd_valid && !o_ready
		&& i_rd_addr > BP_LO_END
		&& (i_rd_addr < BP_HI_START || i_rd_addr > BP_HI_END)
		|=> o_rd_deny) else $error("read outside partition taken");
	a_core_reset: assert property (s_take ##0 i_cmd_code == CMD_RST_CORE
		|=> o_regs_init && o_reset_scope) else $error("core reset missed");
	a_init_clears: assert property (o_regs_init
		|-> !o_busy && !o_int && !o_ready && !o_suspended)
		else $error("outputs not defaulted on reset");
	a_recover_span: assert property (o_regs_init && i_reset_pin_n
		|=> s_recover) else $error("recovery span wrong");
endmodule

bind frbs_sequencer frbs_sequencer_asserts #(.WORDS(WORDS)) u_chk (
	.i_mclk, .i_reset_n, .i_reset_pin_n, .i_cmd_valid, .i_cmd_code,
	.i_rd_valid, .i_rd_addr, .i_rd_status, .o_int, .o_busy, .o_ready,
	.o_suspended, .o_copy_we, .o_copy_addr, .o_regs_init, .o_reset_scope,
	.o_rd_grant, .o_rd_deny, .o_cmd_deny
);

// file: frbs_host.sv
`timescale 1ns/10ps
// host on the memory-style bus: command and read cycles
module frbs_host (
	input wire logic i_mclk, // bus clock
	output logic o_cmd_valid, // command strobe
	output logic [15:0] o_cmd_code, // command code
	output logic o_int_clear, // clears the int bit
	output logic o_rd_valid, // buffer read
	output logic o_rd_status, // status read
	output logic [15:0] o_rd_addr // read address
);
	// ====
	// idle bus
	// ====
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code = 16'hffff;
		o_int_clear = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_status = 1'b0;
		o_rd_addr = 16'hffff;
	end
	// clearing first lets the flag fall to mark the start
	task automatic send(input logic [15:0] c, input bit clr);
		if (clr) begin
			o_int_clear <= 1'b1;
			@(posedge i_mclk);
			o_int_clear <= 1'b0;
		end
		o_cmd_valid <= 1'b1;
		o_cmd_code <= c;
		@(posedge i_mclk);
		o_cmd_valid <= 1'b0;
		o_cmd_code <= ~c; // released bus shows no stale code
		@(posedge i_mclk);
	endtask
	// one read, buffer or status; the edge after keeps strobes apart
	task automatic read(input logic [15:0] a, input bit st);
		o_rd_valid <= !st;
		o_rd_status <= st;
		o_rd_addr <= a;
		@(posedge i_mclk);
		o_rd_valid <= 1'b0;
		o_rd_status <= 1'b0;
		o_rd_addr <= ~a;
		@(posedge i_mclk);
	endtask
endmodule

// file: frbs_sequencer_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("Error t=%0t got %h exp %h", $time, (a), (e)); \
	end \
end
module frbs_sequencer_tb;
	import frbs_pkg::*;
	localparam int PWAIT = 20; // short power-on wait
	localparam int SHORT = 30; // short program, erase, suspend
	localparam int WORDS = 8; // short boot copy
	localparam int STEP = 2; // cycles per copied word
	// op kind to cycles; 0 where the kind runs apart
	int dur [12] = '{SLOAD_CYC, PLOAD_CYC, SHORT, SHORT, SHORT, SHORT,
		0, 0, 0, OTP_CYC, OTP_CYC, VERIFY_CYC};
	logic [15:0] ba [6] = '{16'h0000, 16'h01ff, 16'h8000, 16'h800f,
		16'h0200, 16'h8010}; // first four inside the partition
	logic i_mclk; // clock
	logic i_reset_n = 1'b0; // power reset
	logic i_por_det = 1'b0; // power-on detect
	logic i_reset_pin_n = 1'b0; // pin low at power-up
	logic cmd_valid, int_clear, rd_valid, rd_status; // host side
	logic [15:0] cmd_code, rd_addr; // host side
	logic o_int, o_busy, o_ready, o_suspended, o_copy_we; // flags
	logic [9:0] o_copy_addr; // copy index
	logic o_regs_init, o_reset_scope, o_rd_grant, o_rd_deny, o_cmd_deny;
	bit cmd_q [$]; // expected refusal per command
	bit rd_q [$]; // expected grant per read
	bit exp_b; // oldest note
	int check_count = 0; // comparisons
	int n_mismatch = 0; // mismatches
	int cyc = 0; // clock count
	int n_copy = 0; // copy writes seen
	int n_init = 0; // register init pulses seen
	integer seed = 32'hbfeeedf5; // fixed seed
	logic pv = 1'b0; // command sampled last edge
	frbs_host host (.i_mclk(i_mclk), .o_cmd_valid(cmd_valid),
		.o_cmd_code(cmd_code), .o_int_clear(int_clear),
		.o_rd_valid(rd_valid), .o_rd_status(rd_status), .o_rd_addr(rd_addr));
	frbs_sequencer #(.POR_WAIT(PWAIT), .SPROG(SHORT), .PPROG(SHORT),
		.ERASE1(SHORT), .ERASEN(SHORT), .SUSP(SHORT), .WORDS(WORDS),
		.STEP(STEP)) dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_por_det(i_por_det), .i_reset_pin_n(i_reset_pin_n),
		.i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
		.i_int_clear(int_clear), .i_rd_valid(rd_valid), .i_rd_addr(rd_addr),
		.i_rd_status(rd_status), .o_int(o_int), .o_busy(o_busy),
		.o_ready(o_ready), .o_suspended(o_suspended), .o_copy_we(o_copy_we),
		.o_copy_addr(o_copy_addr), .o_regs_init(o_regs_init),
		.o_reset_scope(o_reset_scope), .o_rd_grant(o_rd_grant),
		.o_rd_deny(o_rd_deny), .o_cmd_deny(o_cmd_deny));
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	// ====
	// monitor: each answer against the oldest note
	// ====
	always @(posedge i_mclk) begin
		cyc++;
		if (o_regs_init) begin
			n_init++;
		end
		if (pv) begin
			exp_b = cmd_q.pop_front();
			`CHK(o_cmd_deny, exp_b)
		end
		if (o_rd_grant | o_rd_deny) begin
			exp_b = rd_q.pop_front();
			`CHK(o_rd_grant, exp_b)
		end
		if (o_copy_we) begin
			`CHK(o_copy_addr, n_copy[9:0])
			n_copy++;
		end
		pv = cmd_valid;
	end
	task automatic cmd(input logic [15:0] c, input bit deny);
		cmd_q.push_back(deny);
		host.send(c, !deny);
	endtask
	task automatic rd(input logic [15:0] a, input bit st, input bit ok);
		rd_q.push_back(ok);
		host.read(a, st);
	endtask
	// bounded wait on the flag (fi) or on the copy count
	task automatic wait_for(input bit fi, input int want, input int lim);
		int n;
		n = 0;
		while ((fi ? o_int !== 1'b1 : n_copy < want) && n < lim) begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= lim) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ====
	// main sequence
	// ====
	initial begin
		int t0;
		int d;
		int dk;
		logic [31:0] r;
		repeat (2) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		@(posedge i_mclk);
		i_por_det <= 1'b1;
		t0 = cyc;
		rd(16'h0000, 1'b0, 1'b0);
		rd(16'h0000, 1'b1, 1'b1);
		cmd(CMD_RST_BP, 1'b1);
		wait_for(1'b0, 1, 200);
		d = cyc - t0;
		`CHK(d >= PWAIT && d <= PWAIT + STEP + 6, 1'b1)
		wait_for(1'b0, WORDS, 200);
		repeat (STEP + 4) @(posedge i_mclk);
		`CHK(o_int, 1'b0)
		for (int i = 0; i < 6; i++) begin
			rd(ba[i], 1'b0, i < 4);
		end
		cmd(16'h0000, 1'b1);
		i_reset_pin_n <= 1'b1;
		wait_for(1'b1, 0, 20);
		`CHK(o_ready, 1'b1)
		// every op kind but suspend and the two resumes, probed while it runs
		for (int k = 0; k < 12; k++) begin
			dk = dur[k];
			if (dk != 0) begin
				cmd({12'h000, 4'(k)}, 1'b0);
				@(negedge i_mclk);
				`CHK({o_busy, o_int}, 2'b10)
				@(posedge i_mclk);
				t0 = cyc;
				r = $random(seed);
				rd({7'h00, r[8:0]}, 1'b0, 1'b1);
				rd(16'h0000, 1'b1, 1'b1);
				cmd({14'h0000, r[10:9]}, 1'b1);
				wait_for(1'b1, 0, dk + 20);
				d = cyc - t0;
				`CHK(d + 3 >= dk && d <= dk + 3, 1'b1)
			end
		end
		// suspend in mid erase, then resume, single then multi block
		for (int e = 0; e < 2; e++) begin
			cmd(16'h0004 + 16'(e), 1'b0);
			repeat (4) @(posedge i_mclk);
			cmd(16'h0006, 1'b0);
			wait_for(1'b1, 0, SHORT + 20);
			`CHK(o_suspended, 1'b1)
			cmd(16'h0007 + 16'(e), 1'b0);
			wait_for(1'b1, 0, SHORT + 20);
			`CHK(o_suspended, 1'b0)
		end
		cmd(16'h0006, 1'b1);
		cmd(16'h0008, 1'b1);
		cmd(16'h000c, 1'b1);
		// both command resets
		cmd(CMD_RST_CORE, 1'b0);
		@(negedge i_mclk);
		`CHK({o_reset_scope, o_ready}, 2'b10)
		@(posedge i_mclk);
		wait_for(1'b1, 0, RECOVER_CYC + 50);
		cmd(CMD_RST_BP, 1'b0);
		@(negedge i_mclk);
		`CHK({o_reset_scope, o_ready}, 2'b00)
		@(posedge i_mclk);
		wait_for(1'b1, 0, RECOVER_CYC + 50);
		// warm reset by the pin
		i_reset_pin_n <= 1'b0;
		repeat (10) @(posedge i_mclk);
		`CHK({o_ready, o_int}, 2'b00)
		rd(16'h0000, 1'b0, 1'b0);
		i_reset_pin_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		rd(16'h800f, 1'b0, 1'b1);
		rd(16'h0300, 1'b0, 1'b0);
		cmd(16'h0000, 1'b1);
		wait_for(1'b1, 0, RECOVER_CYC + 50);
		`CHK(o_ready, 1'b1)
		`CHK(n_init, 3)
		// power lost mid load, cold start again with pin high
		cmd(16'h0001, 1'b0);
		repeat (10) @(posedge i_mclk);
		i_reset_n <= 1'b0;
		@(negedge i_mclk);
		`CHK({o_busy, o_int, o_ready}, 3'b000)
		n_copy = 0;
		@(posedge i_mclk);
		i_reset_n <= 1'b1;
		wait_for(1'b0, WORDS, 200);
		wait_for(1'b1, 0, 50);
		`CHK(o_ready, 1'b1)
		conclude();
	end
endmodule
